//--- rtl/pmc_regs.vh
// Constants for the panel menu controller: register map, fields, keys,
// menu levels and indicator timing.
// Assumes inclusion by bare name from the rtl/ design files.
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// ****************************************************************
// APB register byte offsets
// ****************************************************************
`define PMC_OFS_CTRL      8'h00
`define PMC_OFS_STATUS    8'h04
`define PMC_OFS_PSEL      8'h08
`define PMC_OFS_PDATA     8'h0C
`define PMC_OFS_PATTR     8'h10
`define PMC_OFS_EDIT      8'h14

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define PMC_CTRL_SRC      0
`define PMC_CTRL_PROT_LO  1
`define PMC_CTRL_PROT_HI  2
`define PMC_CTRL_RST      3'h1
`define PMC_PROT_LOCK     2'h1
`define PMC_ATTR_RO       0
`define PMC_ATTR_STOP     1
`define PMC_ST_LEVEL_LO   0
`define PMC_ST_LEVEL_HI   1
`define PMC_ST_DIGIT_LO   2
`define PMC_ST_DIGIT_HI   3
`define PMC_ST_EDITABLE   4
`define PMC_ST_GROUP_LO   8
`define PMC_ST_CODE_LO    16

// ****************************************************************
// Key indices
// ****************************************************************
`define PMC_KEY_PROG      0
`define PMC_KEY_CONF      1
`define PMC_KEY_INC       2
`define PMC_KEY_DEC       3
`define PMC_KEY_SHIFT     4
`define PMC_KEY_RUN       5
`define PMC_KEY_STOP      6
`define PMC_NUM_KEYS      7

// ****************************************************************
// Menu levels
// ****************************************************************
`define PMC_LVL_IDLE      2'h0
`define PMC_LVL_GROUP     2'h1
`define PMC_LVL_CODE      2'h2
`define PMC_LVL_VALUE     2'h3

// ****************************************************************
// Indicator timing
// ****************************************************************
`define PMC_CLK_HZ        100000000
`define PMC_SLOW_HALF_MS  500
`define PMC_FAST_HALF_MS  100

`endif

//--- rtl/pmc_key_sync.v
// Key input conditioner: two-stage synchroniser and press detector.
// Assumes raw key levels from pins, active high, already debounced.
`timescale 1ns/1ps
`default_nettype none

module pmc_key_sync #(
    parameter N = 7
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         ce,
    input  wire [N-1:0] key_in,
    output wire [N-1:0] press
);

    // ****************************************************************
    // Synchroniser stages
    // ****************************************************************
    reg [N-1:0] meta_q;
    reg [N-1:0] sync_q;
    reg [N-1:0] prev_q;

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_key
            // Two flops then a history flop per key
            always @(posedge clk) begin
                if (!rst_n) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                    prev_q[i] <= 1'b0;
                end else if (ce) begin
                    meta_q[i] <= key_in[i];
                    sync_q[i] <= meta_q[i];
                    prev_q[i] <= sync_q[i];
                end
            end
            // One pulse per press
            assign press[i] = sync_q[i] & ~prev_q[i] & ce;
        end
    endgenerate

endmodule // pmc_key_sync

`default_nettype wire

//--- rtl/pmc_blink.v
// Flash timebase: slow and fast square waves for the indicators.
// Assumes one clock; half periods given in clock cycles.
`timescale 1ns/1ps
`default_nettype none

module pmc_blink #(
    parameter SLOW_HALF = 50000000,
    parameter FAST_HALF = 10000000
) (
    input  wire clk,
    input  wire rst_n,
    input  wire ce,
    output reg  slow_q,
    output reg  fast_q
);

    reg [31:0] slow_cnt_q;
    reg [31:0] fast_cnt_q;

    // ****************************************************************
    // Half-period counters
    // ****************************************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            slow_cnt_q <= 32'h0;
            fast_cnt_q <= 32'h0;
            slow_q     <= 1'b0;
            fast_q     <= 1'b0;
        end else if (ce) begin
            if (slow_cnt_q >= SLOW_HALF - 1) begin
                slow_cnt_q <= 32'h0;
                slow_q     <= ~slow_q;
            end else begin
                slow_cnt_q <= slow_cnt_q + 32'h1;
            end
            if (fast_cnt_q >= FAST_HALF - 1) begin
                fast_cnt_q <= 32'h0;
                fast_q     <= ~fast_q;
            end else begin
                fast_cnt_q <= fast_cnt_q + 32'h1;
            end
        end
    end

endmodule // pmc_blink

`default_nettype wire

//--- rtl/pmc_top.v
// Front-panel menu controller for a motor drive: keypad menu, parameter
// store, run/stop/reset commands, indicator LEDs and an APB slave.
// Assumes debounced key pins and drive status from same-clock logic.
//
// Decided for this implementation: the register offsets and register access over APB.
`include "pmc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Menu has three levels: group, function code, value.
// - Program key enters level one or steps back one level.
// - Confirm key accepts data or descends one level.
// - Increment/decrement step group, code or value by level.
// - Shift key moves the edit digit while editing a value.
// - Run key starts the drive when keypad is command source.
// - Stop key stops a running drive.
// - Stop key resets a faulted drive instead of stopping.
// - Confirm at value level saves, returns, selects next code.
// - Program at value level discards edit, keeps same code.
// - Value flashes only when editable; steady means refused.
// - Read-only codes never accept keypad changes.
// - Stop-only codes refuse edits while running.
module pmc_top #(
    parameter GROUP_W   = 3,
    parameter CODE_W    = 4,
    parameter VAL_W     = 16,
    parameter SLOW_HALF = `PMC_SLOW_HALF_MS * (`PMC_CLK_HZ / 1000),
    parameter FAST_HALF = `PMC_FAST_HALF_MS * (`PMC_CLK_HZ / 1000)
) (
    input  wire                     clk,
    input  wire                     rst_n,
    input  wire                     ce,
    input  wire [`PMC_NUM_KEYS-1:0] key_in,
    input  wire                     drive_running,
    input  wire                     drive_fault,
    input  wire                     drive_reverse,
    input  wire                     torque_mode,
    input  wire                     tuning_mode,
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [7:0]               paddr,
    input  wire [31:0]              pwdata,
    output reg  [31:0]              prdata,
    output reg                      pready,
    output reg                      pslverr,
    output reg                      cmd_start_q,
    output reg                      cmd_stop_q,
    output reg                      cmd_fault_reset_q,
    output reg                      led_run_q,
    output reg                      led_dir_q,
    output reg                      led_fault_q,
    output reg  [1:0]               menu_level_q,
    output reg  [GROUP_W-1:0]       disp_group_q,
    output reg  [CODE_W-1:0]        disp_code_q,
    output reg  [VAL_W-1:0]         disp_value_q,
    output reg  [1:0]               disp_digit_q,
    output reg                      disp_flash_q
);

    localparam ADDR_W = GROUP_W + CODE_W;
    localparam DEPTH  = 1 << ADDR_W;
    localparam DIG_W  = 2;

    // ****************************************************************
    // Storage and state
    // ****************************************************************
    reg [VAL_W-1:0]   param_mem [0:DEPTH-1];
    reg [1:0]         attr_mem  [0:DEPTH-1];
    reg [2:0]         ctrl_q;
    reg [ADDR_W-1:0]  host_idx_q;
    reg [1:0]         level_q;
    reg [GROUP_W-1:0] group_q;
    reg [CODE_W-1:0]  code_q;
    reg [VAL_W-1:0]   edit_q;
    reg [DIG_W-1:0]   digit_q;

    wire [`PMC_NUM_KEYS-1:0] press;
    wire                     slow;
    wire                     fast;
    wire [ADDR_W-1:0]        sel_idx;
    wire [VAL_W-1:0]         step;
    wire                     editable;
    wire                     setup;
    wire                     wr_acc;
    wire                     keypad_src;

    // ****************************************************************
    // Sub-blocks
    // ****************************************************************
    pmc_key_sync #(
        .N (`PMC_NUM_KEYS)
    ) u_keys (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .key_in (key_in),
        .press  (press)
    );

    pmc_blink #(
        .SLOW_HALF (SLOW_HALF),
        .FAST_HALF (FAST_HALF)
    ) u_blink (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .slow_q (slow),
        .fast_q (fast)
    );

    // ****************************************************************
    // Edit permission
    // ****************************************************************
    // Decides whether a code may be changed now
    function can_edit;
        input [1:0] attr;
        input       running;
        input [1:0] prot;
        begin
            can_edit = !attr[`PMC_ATTR_RO]
                       && !(attr[`PMC_ATTR_STOP] && running)
                       && (prot != `PMC_PROT_LOCK);
        end
    endfunction

    // Selected code and digit step
    assign sel_idx    = {group_q, code_q};
    assign step       = {{(VAL_W-1){1'b0}}, 1'b1} << {digit_q, 2'b00};
    assign keypad_src = ctrl_q[`PMC_CTRL_SRC];
    assign editable   = can_edit(attr_mem[sel_idx], drive_running,
                                 ctrl_q[`PMC_CTRL_PROT_HI:`PMC_CTRL_PROT_LO]);

    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & pready;

    // ****************************************************************
    // Menu navigation
    // ****************************************************************
    // three menu levels
    always @(posedge clk) begin
        if (!rst_n) begin
            level_q <= `PMC_LVL_IDLE;
            group_q <= {GROUP_W{1'b0}};
            code_q  <= {CODE_W{1'b0}};
            edit_q  <= {VAL_W{1'b0}};
            digit_q <= {DIG_W{1'b0}};
        end else if (ce) begin
            case (level_q)
                `PMC_LVL_IDLE: begin
                    if (press[`PMC_KEY_PROG]) begin
                        level_q <= `PMC_LVL_GROUP;
                    end
                end
                `PMC_LVL_GROUP: begin
                    if (press[`PMC_KEY_PROG]) begin
                        level_q <= `PMC_LVL_IDLE;
                    end else if (press[`PMC_KEY_CONF]) begin
                        level_q <= `PMC_LVL_CODE;
                        code_q  <= {CODE_W{1'b0}};
                    end else if (press[`PMC_KEY_INC]) begin
                        group_q <= group_q + {{(GROUP_W-1){1'b0}}, 1'b1};
                    end else if (press[`PMC_KEY_DEC]) begin
                        group_q <= group_q - {{(GROUP_W-1){1'b0}}, 1'b1};
                    end
                end
                `PMC_LVL_CODE: begin
                    if (press[`PMC_KEY_PROG]) begin
                        level_q <= `PMC_LVL_GROUP;
                    end else if (press[`PMC_KEY_CONF]) begin
                        level_q <= `PMC_LVL_VALUE;
                        edit_q  <= param_mem[sel_idx];
                        digit_q <= {DIG_W{1'b0}};
                    end else if (press[`PMC_KEY_INC]) begin
                        code_q <= code_q + {{(CODE_W-1){1'b0}}, 1'b1};
                    end else if (press[`PMC_KEY_DEC]) begin
                        code_q <= code_q - {{(CODE_W-1){1'b0}}, 1'b1};
                    end
                end
                `PMC_LVL_VALUE: begin
                    if (press[`PMC_KEY_PROG]) begin
                        level_q <= `PMC_LVL_CODE;
                    end else if (press[`PMC_KEY_CONF]) begin
                        level_q <= `PMC_LVL_CODE;
                        code_q  <= code_q + {{(CODE_W-1){1'b0}}, 1'b1};
                    end else if (press[`PMC_KEY_INC] && editable) begin
                        edit_q <= edit_q + step;
                    end else if (press[`PMC_KEY_DEC] && editable) begin
                        edit_q <= edit_q - step;
                    end else if (press[`PMC_KEY_SHIFT] && editable) begin
                        digit_q <= digit_q + {{(DIG_W-1){1'b0}}, 1'b1};
                    end
                end
                default: begin
                    level_q <= `PMC_LVL_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Parameter store
    // ****************************************************************
    // Keypad save wins over a host data write in the same cycle; store holds no reset
    always @(posedge clk) begin
        if (rst_n && ce) begin
            if (level_q == `PMC_LVL_VALUE && press[`PMC_KEY_CONF]
                && editable) begin
                param_mem[sel_idx] <= edit_q;
            end else if (wr_acc && paddr == `PMC_OFS_PDATA) begin
                param_mem[host_idx_q] <= pwdata[VAL_W-1:0];
            end
            if (wr_acc && paddr == `PMC_OFS_PATTR) begin
                attr_mem[host_idx_q] <= pwdata[1:0];
            end
        end
    end

    // ****************************************************************
    // Drive commands
    // ****************************************************************
    // One-cycle command pulses
    always @(posedge clk) begin
        if (!rst_n) begin
            cmd_start_q       <= 1'b0;
            cmd_stop_q        <= 1'b0;
            cmd_fault_reset_q <= 1'b0;
        end else if (ce) begin
            cmd_start_q <= press[`PMC_KEY_RUN] && keypad_src
                           && !drive_running && !drive_fault;
            cmd_fault_reset_q <= press[`PMC_KEY_STOP] && drive_fault;
            cmd_stop_q <= press[`PMC_KEY_STOP] && !drive_fault
                          && drive_running;
        end else begin
            cmd_start_q       <= 1'b0;
            cmd_stop_q        <= 1'b0;
            cmd_fault_reset_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Indicators and display
    // ****************************************************************
    // Registered LED and display outputs
    always @(posedge clk) begin
        if (!rst_n) begin
            led_run_q    <= 1'b0;
            led_dir_q    <= 1'b0;
            led_fault_q  <= 1'b0;
            menu_level_q <= `PMC_LVL_IDLE;
            disp_group_q <= {GROUP_W{1'b0}};
            disp_code_q  <= {CODE_W{1'b0}};
            disp_value_q <= {VAL_W{1'b0}};
            disp_digit_q <= 2'h0;
            disp_flash_q <= 1'b0;
        end else if (ce) begin
            led_run_q <= drive_running;
            led_dir_q <= drive_reverse;
            if (drive_fault) begin
                led_fault_q <= fast;
            end else if (tuning_mode) begin
                led_fault_q <= slow;
            end else begin
                led_fault_q <= torque_mode;
            end
            menu_level_q <= level_q;
            disp_group_q <= group_q;
            disp_code_q  <= code_q;
            disp_value_q <= edit_q;
            disp_digit_q <= digit_q;
            disp_flash_q <= (level_q == `PMC_LVL_VALUE) && editable;
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Control and index registers
    always @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q     <= `PMC_CTRL_RST;
            host_idx_q <= {ADDR_W{1'b0}};
        end else if (ce && wr_acc) begin
            if (paddr == `PMC_OFS_CTRL) begin
                ctrl_q <= pwdata[2:0];
            end
            if (paddr == `PMC_OFS_PSEL) begin
                host_idx_q <= pwdata[ADDR_W-1:0];
            end
        end
    end

    // Read data and error latched in setup, zero wait access
    always @(posedge clk) begin
        if (!rst_n) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= setup;
            if (setup) begin
                prdata  <= 32'h0;
                pslverr <= 1'b0;
                case (paddr)
                    `PMC_OFS_CTRL: begin
                        prdata[2:0] <= ctrl_q;
                    end
                    `PMC_OFS_STATUS: begin
                        prdata[`PMC_ST_LEVEL_HI:`PMC_ST_LEVEL_LO] <= level_q;
                        prdata[`PMC_ST_DIGIT_HI:`PMC_ST_DIGIT_LO] <= digit_q;
                        prdata[`PMC_ST_EDITABLE] <= editable;
                        prdata[`PMC_ST_GROUP_LO +: GROUP_W] <= group_q;
                        prdata[`PMC_ST_CODE_LO +: CODE_W]   <= code_q;
                    end
                    `PMC_OFS_PSEL: begin
                        prdata[ADDR_W-1:0] <= host_idx_q;
                    end
                    `PMC_OFS_PDATA: begin
                        prdata[VAL_W-1:0] <= param_mem[host_idx_q];
                    end
                    `PMC_OFS_PATTR: begin
                        prdata[1:0] <= attr_mem[host_idx_q];
                    end
                    `PMC_OFS_EDIT: begin
                        prdata[VAL_W-1:0] <= edit_q;
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end else begin
            pready <= 1'b0;
        end
    end

endmodule // pmc_top

`default_nettype wire

//--- bench/pmc_asserts.sv
// Port timing checker for the panel menu controller.
// Assumes one clock domain and binding onto pmc_top.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Checker
// ****************************************
module pmc_asserts (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       ce,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       drive_running,
    input wire logic       drive_fault,
    input wire logic       drive_reverse,
    input wire logic       cmd_start_q,
    input wire logic       cmd_stop_q,
    input wire logic       cmd_fault_reset_q,
    input wire logic       led_run_q,
    input wire logic       led_dir_q,
    input wire logic [1:0] menu_level_q,
    input wire logic       disp_flash_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_apb_ready_slot: assert property (psel && !penable && ce |=> pready)
        else $error("pready missing after setup");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    chk_unmapped_err: assert property (pready && paddr > 8'h14 |-> pslverr)
        else $error("no error on unmapped offset");
    chk_start_gate: assert property (cmd_start_q |-> !$past(drive_running) && !$past(drive_fault))
        else $error("start while running or faulted");
    chk_start_pulse: assert property (cmd_start_q |=> !cmd_start_q)
        else $error("start pulse too long");
    chk_stop_gate: assert property (cmd_stop_q |-> $past(drive_running) && !$past(drive_fault))
        else $error("stop without running drive");
    chk_reset_gate: assert property (cmd_fault_reset_q |-> $past(drive_fault))
        else $error("fault reset without fault");
    chk_flash_level: assert property (disp_flash_q |-> menu_level_q == 2'h3)
        else $error("flash outside value level");
    chk_run_lamp: assert property ($rose(drive_running) |-> ##[1:2] led_run_q)
        else $error("run lamp late");
    chk_dir_lamp: assert property ($rose(drive_reverse) |-> ##[1:2] led_dir_q)
        else $error("direction lamp late");
    cov_start: cover property (cmd_start_q);
    cov_reset: cover property (cmd_fault_reset_q);
    cov_flash: cover property (disp_flash_q);
endmodule // pmc_asserts
bind pmc_top pmc_asserts i_chk (.*);
`default_nettype wire

//--- bench/pmc_operator.sv
// Operator model: presses one key at a time, held then released.
// Assumes tb calls tap right after a clock edge.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Operator
// ****************************************
module pmc_operator (
    input  wire logic       clk,
    output var  logic [6:0] key_in
);
    initial key_in = 7'h00;
    // One press, long enough for the synchroniser
    task tap(input int k);
        @(posedge clk) key_in[k] <= 1'b1;
        repeat (4) @(posedge clk);
        key_in[k] <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
endmodule // pmc_operator
`default_nettype wire

//--- bench/tb_panel_menu_controller.sv
// Testbench for pmc_top: APB master, operator keys, drive levels.
// Assumes rtl/ on the include path.
`include "pmc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench
// ****************************************
module tb_panel_menu_controller;
    logic clk = 0, rst_n = 0, ce = 1, run = 0, flt = 0, rev = 0, tq = 0, tun = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, err_q;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [6:0]  key_in;
    logic st, sp, fr, lr, ld, lf, fl;
    logic [1:0]  lvl, dig;
    logic [2:0]  grp;
    logic [3:0]  code;
    logic [15:0] val;
    int errors = 0, checks_done = 0, n_st = 0, n_sp = 0, n_fr = 0;
    always #5 clk = ~clk;
    pmc_operator i_op (.clk(clk), .key_in(key_in));
    pmc_top #(.SLOW_HALF(8), .FAST_HALF(2)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .key_in(key_in), .drive_running(run), .drive_fault(flt), .drive_reverse(rev),
        .torque_mode(tq), .tuning_mode(tun), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmd_start_q(st), .cmd_stop_q(sp),
        .cmd_fault_reset_q(fr), .led_run_q(lr), .led_dir_q(ld), .led_fault_q(lf),
        .menu_level_q(lvl), .disp_group_q(grp), .disp_code_q(code),
        .disp_value_q(val), .disp_digit_q(dig), .disp_flash_q(fl));
    // Command pulse counters
    always @(posedge clk) begin
        n_st <= n_st + st;
        n_sp <= n_sp + sp;
        n_fr <= n_fr + fr;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task tap(input int k);
        i_op.tap(k);
    endtask
    // Counts fault lamp changes over 16 cycles after settling
    task lamp(input int e);
        int n;
        logic p;
        n = 0;
        repeat (3) @(posedge clk);
        p = lf;
        repeat (16) begin
            @(posedge clk);
            if (lf !== p) n++;
            p = lf;
        end
        chk(n, e);
    endtask
    task t_regs;
        apb(0, `PMC_OFS_CTRL, 0); chk(rd, 32'h1);
        apb(0, 8'h18, 0); chk(err_q, 32'h1); chk(rd, 32'h0);
        apb(1, `PMC_OFS_PSEL, 32'h0); apb(1, `PMC_OFS_PDATA, 32'h1234);
        apb(1, `PMC_OFS_PATTR, 32'h0); apb(1, `PMC_OFS_PSEL, 32'h1);
        apb(1, `PMC_OFS_PDATA, 32'hAA); apb(1, `PMC_OFS_PATTR, 32'h2);
        apb(0, `PMC_OFS_PDATA, 0); chk(rd, 32'hAA);
    endtask
    task t_edit;
        tap(`PMC_KEY_PROG); chk(lvl, `PMC_LVL_GROUP);
        tap(`PMC_KEY_INC); chk(grp, 3'h1);
        tap(`PMC_KEY_DEC); chk(grp, 3'h0);
        tap(`PMC_KEY_CONF); chk({lvl, code}, {`PMC_LVL_CODE, 4'h0});
        tap(`PMC_KEY_INC); chk(code, 4'h1);
        tap(`PMC_KEY_DEC); chk(code, 4'h0);
        tap(`PMC_KEY_CONF); chk({lvl, val, fl}, {`PMC_LVL_VALUE, 16'h1234, 1'b1});
        tap(`PMC_KEY_INC); chk(val, 16'h1235);
        tap(`PMC_KEY_SHIFT); chk(dig, 2'h1);
        tap(`PMC_KEY_INC); chk(val, 16'h1245);
        tap(`PMC_KEY_CONF); chk({lvl, code}, {`PMC_LVL_CODE, 4'h1});
        apb(1, `PMC_OFS_PSEL, 32'h0); apb(0, `PMC_OFS_PDATA, 0); chk(rd, 32'h1245);
        apb(0, `PMC_OFS_STATUS, 0); chk(rd, 32'h0001_0016);
        apb(0, `PMC_OFS_EDIT, 0); chk(rd, 32'h1245);
    endtask
    task t_lock;
        run <= 1'b1;
        tap(`PMC_KEY_CONF); chk({val, fl}, {16'hAA, 1'b0});
        tap(`PMC_KEY_INC); chk(val, 16'hAA);
        tap(`PMC_KEY_PROG); chk({lvl, code}, {`PMC_LVL_CODE, 4'h1});
        run <= 1'b0;
        apb(1, `PMC_OFS_CTRL, 32'h3);
        tap(`PMC_KEY_CONF); chk(fl, 1'b0);
        tap(`PMC_KEY_INC); chk(val, 16'hAA);
        tap(`PMC_KEY_PROG); apb(1, `PMC_OFS_CTRL, 32'h1);
        tap(`PMC_KEY_CONF); chk(fl, 1'b1);
        tap(`PMC_KEY_INC); chk(val, 16'hAB);
        tap(`PMC_KEY_PROG); chk({lvl, code}, {`PMC_LVL_CODE, 4'h1});
        apb(1, `PMC_OFS_PSEL, 32'h1); apb(0, `PMC_OFS_PDATA, 0); chk(rd, 32'hAA);
        apb(1, `PMC_OFS_PATTR, 32'h1);
        tap(`PMC_KEY_CONF); chk(fl, 1'b0);
        tap(`PMC_KEY_INC); chk(val, 16'hAA);
        tap(`PMC_KEY_PROG);
    endtask
    task t_cmd;
        tap(`PMC_KEY_RUN); chk(n_st, 1);
        run <= 1'b1; rev <= 1'b1;
        tap(`PMC_KEY_RUN); chk({n_st, lr, ld}, {32'd1, 2'b11});
        tap(`PMC_KEY_STOP); chk(n_sp, 1);
        flt <= 1'b1;
        tap(`PMC_KEY_STOP); chk(n_sp, 1); chk(n_fr, 1);
        lamp(8);
        flt <= 1'b0; tun <= 1'b1;
        lamp(2);
        tun <= 1'b0; tq <= 1'b1;
        lamp(0); chk(lf, 1'b1);
        tq <= 1'b0; run <= 1'b0;
        apb(1, `PMC_OFS_CTRL, 32'h0);
        tap(`PMC_KEY_RUN); chk({n_st, lr}, {32'd1, 1'b0});
    endtask
    task test_done;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_regs; t_edit; t_lock; t_cmd;
        test_done;
    end
    // Watchdog
    initial begin
        #200000;
        errors++;
        test_done;
    end
endmodule // tb_panel_menu_controller
`default_nettype wire
